//--- design/efi_pkg.sv
package efi_pkg;

	// ****************************************************************
	// register access
	// ****************************************************************
	localparam int EFI_ADDR_W = 8;
	localparam int EFI_DATA_W = 8;
	localparam logic [7:0] EFI_OFS_EN_LO = 8'h15;
	localparam logic [7:0] EFI_OFS_EN_HI = 8'h16;
	localparam logic [7:0] EFI_OFS_FLG_LO = 8'h18;
	localparam logic [7:0] EFI_OFS_FLG_HI = 8'h19;
	localparam logic [7:0] EFI_RST_EN_LO = 8'h01;
	localparam logic [7:0] EFI_RST_EN_HI = 8'h00;
	localparam logic [7:0] EFI_RST_FLG = 8'h00;
	localparam logic [7:0] EFI_RD_UNMAPPED = 8'h00;

	// ****************************************************************
	// bit positions of the low flag / enable group
	// ****************************************************************
	localparam int EFI_LO_CHARGER = 7;
	localparam int EFI_LO_DIS_TEMP = 6;
	localparam int EFI_LO_CH_TEMP = 5;
	localparam int EFI_LO_SRC_LOW = 4;
	localparam int EFI_LO_OVCH = 3;
	localparam int EFI_LO_CHRDY = 2;
	localparam int EFI_LO_OVDIS = 1;
	localparam int EFI_LO_IF_RDY = 0;

	// ****************************************************************
	// bit positions of the high flag / enable group
	// ****************************************************************
	localparam int EFI_HI_PM_ERR = 7;
	localparam int EFI_HI_PM_DONE = 6;
	localparam int EFI_HI_TEMP_DONE = 5;
	localparam int EFI_HI_STO_DONE = 4;
	localparam int EFI_HI_SRC2_DONE = 3;
	localparam int EFI_HI_SRC2_START = 2;
	localparam int EFI_HI_SRC1_DONE = 1;
	localparam int EFI_HI_SRC1_START = 0;

	// ****************************************************************
	// indices of the asynchronous level inputs in the sync vector
	// ****************************************************************
	localparam int EFI_LV_CHARGER = 0;
	localparam int EFI_LV_COLD_DIS = 1;
	localparam int EFI_LV_HOT_DIS = 2;
	localparam int EFI_LV_COLD_CH = 3;
	localparam int EFI_LV_HOT_CH = 4;
	localparam int EFI_LV_SRC1_LOW = 5;
	localparam int EFI_LV_SRC2_LOW = 6;
	localparam int EFI_LV_OVCH = 7;
	localparam int EFI_LV_CHRDY = 8;
	localparam int EFI_LV_OVDIS = 9;
	localparam int EFI_LV_IF_RDY = 10;
	localparam int EFI_LV_W = 11;

	// ****************************************************************
	// timing
	// ****************************************************************
	localparam longint EFI_REF_CLK_HZ = 25_000_000;
	localparam longint EFI_OVDIS_PERSIST_US = 1000; // plain default, no figure given
	// least time: round up to whole cycles
	localparam longint EFI_OVDIS_PERSIST_CYC_L =
		(EFI_OVDIS_PERSIST_US * EFI_REF_CLK_HZ + 999_999) / 1_000_000;
	localparam int unsigned EFI_OVDIS_PERSIST_CYC = int'(EFI_OVDIS_PERSIST_CYC_L);
	localparam int EFI_CNT_W = 24;

	// overdischarge persistence tracker
	typedef enum logic [1:0] {
		EFI_OD_ABOVE,
		EFI_OD_TIMING,
		EFI_OD_BELOW
	} efi_od_state_t;

endpackage

//--- design/efi_level_sync.sv
`timescale 1ns/1ps
module efi_level_sync #(
	parameter int W = 1
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] level,
	output logic [W-1:0] change
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] lvl;
	} efi_sync_state_t;

	efi_sync_state_t st_q;
	efi_sync_state_t st_d;
	logic [W-1:0] agree;

	// three-stage shift; accepted level moves only when stages two and three agree
	always_comb begin
		st_d = st_q;
		st_d.s1 = async_in;
		st_d.s2 = st_q.s1;
		st_d.s3 = st_q.s2;
		agree = ~(st_q.s2 ^ st_q.s3);
		st_d.lvl = (agree & st_q.s3) | (~agree & st_q.lvl);
	end

	// state register
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	// level is the accepted value, change pulses one cycle before it toggles
	assign level = st_q.lvl;
	assign change = st_d.lvl ^ st_q.lvl;

endmodule // efi_level_sync

//--- design/efi_event_flags.sv
// Functional notes
// R1: enabled event sets its flag and raises irq
// R2: flag and irq hold until register read
// R3: disabled event sets nothing, no irq
// R4: low flags at 0x18, read-only, reset zero
// R5: high flags at 0x19, read-only, reset zero
// R6: low bit7: charger connect or disconnect
// R7: low bit6: discharge temperature limit crossed
// R8: low bit5: charge temperature limit crossed
// R9: low bit4: both-sources-low state changes
// R10: low bit3: overcharge threshold crossed
// R11: low bit2: charge-ready threshold crossed
// R12: low bit1: overdischarge after delay, rise immediate
// R13: low bit0: serial interface became ready
// R14: high bit7: power monitor error
// R15: high bit6: power monitor data ready
// R16: high bit5: temperature measurement done
// R17: high bit4: storage measurement done
// R18: second source: bit2 start, bit3 done
// R19: first source: bit0 start, bit1 done
// R20: enables keep governing after strap fallback
// R21: low enables at 0x15, reset 0x01
// R22: high enables at 0x16, reset zero
// R23: irq is OR of all flags
// R24: event during read-clear stays pending
// R25: host reads both flag registers after irq
`timescale 1ns/1ps
module efi_event_flags
	import efi_pkg::*;
#(
	parameter int unsigned OVDIS_PERSIST_CYC = efi_pkg::EFI_OVDIS_PERSIST_CYC
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	// asynchronous comparator and detector levels
	input wire logic charger_connected,
	input wire logic temp_cold_dis,
	input wire logic temp_hot_dis,
	input wire logic temp_cold_ch,
	input wire logic temp_hot_ch,
	input wire logic src1_low,
	input wire logic src2_low,
	input wire logic sto_above_ovch,
	input wire logic sto_above_chrdy,
	input wire logic sto_below_ovdis,
	input wire logic serial_if_ready,
	// one-cycle event pulses from logic on ref_clk
	input wire logic power_monitor_error,
	input wire logic power_monitor_done,
	input wire logic temp_measure_done,
	input wire logic storage_measure_done,
	input wire logic second_source_track_done,
	input wire logic second_source_track_start,
	input wire logic first_source_track_done,
	input wire logic first_source_track_start,
	// register port from the serial interface
	input wire logic [efi_pkg::EFI_ADDR_W-1:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [efi_pkg::EFI_DATA_W-1:0] reg_wdata,
	input wire logic reg_rd,
	output logic [efi_pkg::EFI_DATA_W-1:0] reg_rdata,
	output logic irq
);

	import efi_pkg::*;

	// ****************************************************************
	// state
	// ****************************************************************
	typedef struct packed {
		logic [EFI_DATA_W-1:0] en_lo;
		logic [EFI_DATA_W-1:0] en_hi;
		logic [EFI_DATA_W-1:0] flg_lo;
		logic [EFI_DATA_W-1:0] flg_hi;
		logic [EFI_DATA_W-1:0] rdata;
		logic irq;
		logic both_low;
		efi_od_state_t od_state;
		logic [EFI_CNT_W-1:0] od_cnt;
	} efi_state_t;

	efi_state_t st_q;
	efi_state_t st_d;

	localparam logic [EFI_CNT_W-1:0] OD_LAST = EFI_CNT_W'(OVDIS_PERSIST_CYC - 1);

	// ****************************************************************
	// helpers
	// ****************************************************************

	// address hit on one register offset
	function automatic logic efi_hit(
		input logic [EFI_ADDR_W-1:0] addr,
		input logic [EFI_ADDR_W-1:0] ofs
	);
		return addr == ofs;
	endfunction

	// a level crossing: change pulse of either of two levels
	function automatic logic efi_either(
		input logic [EFI_LV_W-1:0] chg,
		input int a,
		input int b
	);
		return chg[a] | chg[b];
	endfunction

	// next value of one flag register: read clears, a gated event still sets
	function automatic logic [EFI_DATA_W-1:0] efi_flag_next(
		input logic [EFI_DATA_W-1:0] flg,
		input logic clr,
		input logic [EFI_DATA_W-1:0] ev,
		input logic [EFI_DATA_W-1:0] en
	);
		logic [EFI_DATA_W-1:0] kept;
		logic [EFI_DATA_W-1:0] fresh;
		kept = clr ? EFI_RST_FLG : flg; // R2
		fresh = ev & en; // R1 R3
		return kept | fresh; // R24
	endfunction

	// strobe aimed at one register offset
	function automatic logic efi_strobe_at(
		input logic strobe,
		input logic [EFI_ADDR_W-1:0] addr,
		input logic [EFI_ADDR_W-1:0] ofs
	);
		return strobe & efi_hit(addr, ofs);
	endfunction

	// any flag of either register still set
	function automatic logic efi_any_set(
		input logic [EFI_DATA_W-1:0] lo,
		input logic [EFI_DATA_W-1:0] hi
	);
		return |{lo, hi};
	endfunction

	// ****************************************************************
	// input synchronisation
	// ****************************************************************
	logic [EFI_LV_W-1:0] lv_raw;
	logic [EFI_LV_W-1:0] lv;
	logic [EFI_LV_W-1:0] lv_chg;
	logic [EFI_LV_W-1:0] lv_new;

	// gather the asynchronous levels into one vector
	always_comb begin
		lv_raw = '0;
		lv_raw[EFI_LV_CHARGER] = charger_connected;
		lv_raw[EFI_LV_COLD_DIS] = temp_cold_dis;
		lv_raw[EFI_LV_HOT_DIS] = temp_hot_dis;
		lv_raw[EFI_LV_COLD_CH] = temp_cold_ch;
		lv_raw[EFI_LV_HOT_CH] = temp_hot_ch;
		lv_raw[EFI_LV_SRC1_LOW] = src1_low;
		lv_raw[EFI_LV_SRC2_LOW] = src2_low;
		lv_raw[EFI_LV_OVCH] = sto_above_ovch;
		lv_raw[EFI_LV_CHRDY] = sto_above_chrdy;
		lv_raw[EFI_LV_OVDIS] = sto_below_ovdis;
		lv_raw[EFI_LV_IF_RDY] = serial_if_ready;
	end

	// three-flop synchroniser with agreement filter
	efi_level_sync #(
		.W(EFI_LV_W)
	) u_sync (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.async_in(lv_raw),
		.level(lv),
		.change(lv_chg)
	);

	// accepted level as it will stand after this edge
	assign lv_new = lv ^ lv_chg;

	// ****************************************************************
	// event detection
	// ****************************************************************
	logic [EFI_DATA_W-1:0] ev_lo;
	logic [EFI_DATA_W-1:0] ev_hi;
	logic both_low_now;
	logic od_event;
	efi_od_state_t od_state_d;
	logic [EFI_CNT_W-1:0] od_cnt_d;
	logic dis_temp_cross;
	logic ch_temp_cross;
	logic if_ready_rise;

	// both sources below their low thresholds
	assign both_low_now = lv_new[EFI_LV_SRC1_LOW] & lv_new[EFI_LV_SRC2_LOW];

	// overdischarge persistence tracker, next values kept apart from the state copy
	always_comb begin
		od_event = 1'b0;
		od_state_d = st_q.od_state;
		od_cnt_d = st_q.od_cnt;
		// counter runs only while the accepted level stays below
		case (st_q.od_state)
			EFI_OD_ABOVE: begin
				if (lv[EFI_LV_OVDIS]) begin
					od_state_d = EFI_OD_TIMING;
					od_cnt_d = '0;
				end
			end
			EFI_OD_TIMING: begin
				if (!lv[EFI_LV_OVDIS]) begin
					// short dip: never declared, no event
					od_state_d = EFI_OD_ABOVE;
				end else if (st_q.od_cnt >= OD_LAST) begin
					od_state_d = EFI_OD_BELOW; // R12
					od_event = 1'b1; // R12
				end else begin
					od_cnt_d = st_q.od_cnt + EFI_CNT_W'(1);
				end
			end
			EFI_OD_BELOW: begin
				if (!lv[EFI_LV_OVDIS]) begin
					od_state_d = EFI_OD_ABOVE; // R12
					od_event = 1'b1; // R12
				end
			end
			default: begin
				od_state_d = EFI_OD_ABOVE;
			end
		endcase
	end

	// crossings that merge two levels, and the ready rise
	assign dis_temp_cross = efi_either(lv_chg, EFI_LV_COLD_DIS, EFI_LV_HOT_DIS); // R7
	assign ch_temp_cross = efi_either(lv_chg, EFI_LV_COLD_CH, EFI_LV_HOT_CH); // R8
	assign if_ready_rise = lv_chg[EFI_LV_IF_RDY] & lv_new[EFI_LV_IF_RDY]; // R13

	// low group events from accepted level changes
	always_comb begin
		ev_lo = '0;
		ev_lo[EFI_LO_CHARGER] = lv_chg[EFI_LV_CHARGER]; // R6
		ev_lo[EFI_LO_DIS_TEMP] = dis_temp_cross; // R7
		ev_lo[EFI_LO_CH_TEMP] = ch_temp_cross; // R8
		ev_lo[EFI_LO_SRC_LOW] = both_low_now ^ st_q.both_low; // R9
		ev_lo[EFI_LO_OVCH] = lv_chg[EFI_LV_OVCH]; // R10
		ev_lo[EFI_LO_CHRDY] = lv_chg[EFI_LV_CHRDY]; // R11
		ev_lo[EFI_LO_OVDIS] = od_event; // R12
		ev_lo[EFI_LO_IF_RDY] = if_ready_rise; // R13
	end

	// high group events straight from the measurement pulses
	always_comb begin
		ev_hi = '0;
		ev_hi[EFI_HI_PM_ERR] = power_monitor_error; // R14
		ev_hi[EFI_HI_PM_DONE] = power_monitor_done; // R15
		ev_hi[EFI_HI_TEMP_DONE] = temp_measure_done; // R16
		ev_hi[EFI_HI_STO_DONE] = storage_measure_done; // R17
		ev_hi[EFI_HI_SRC2_DONE] = second_source_track_done; // R18
		ev_hi[EFI_HI_SRC2_START] = second_source_track_start; // R18
		ev_hi[EFI_HI_SRC1_DONE] = first_source_track_done; // R19
		ev_hi[EFI_HI_SRC1_START] = first_source_track_start; // R19
	end

	// ****************************************************************
	// register file
	// ****************************************************************
	logic rd_flg_lo;
	logic rd_flg_hi;
	logic wr_en_lo;
	logic wr_en_hi;
	logic [EFI_DATA_W-1:0] rd_mux;

	// access decode; flag offsets take no write
	assign rd_flg_lo = efi_strobe_at(reg_rd, reg_addr, EFI_OFS_FLG_LO); // R4
	assign rd_flg_hi = efi_strobe_at(reg_rd, reg_addr, EFI_OFS_FLG_HI); // R5
	assign wr_en_lo = efi_strobe_at(reg_wr, reg_addr, EFI_OFS_EN_LO); // R21
	assign wr_en_hi = efi_strobe_at(reg_wr, reg_addr, EFI_OFS_EN_HI); // R22

	// read data select; unmapped offsets read as zero
	always_comb begin
		if (efi_hit(reg_addr, EFI_OFS_EN_LO)) begin
			rd_mux = st_q.en_lo;
		end else if (efi_hit(reg_addr, EFI_OFS_EN_HI)) begin
			rd_mux = st_q.en_hi;
		end else if (efi_hit(reg_addr, EFI_OFS_FLG_LO)) begin
			rd_mux = st_q.flg_lo; // R4
		end else if (efi_hit(reg_addr, EFI_OFS_FLG_HI)) begin
			rd_mux = st_q.flg_hi; // R5
		end else begin
			rd_mux = EFI_RD_UNMAPPED;
		end
	end

	// enables, flags, read data and irq next values
	always_comb begin
		st_d.en_lo = st_q.en_lo;
		st_d.en_hi = st_q.en_hi;
		st_d.rdata = st_q.rdata;
		// both-low state remembered for the next edge
		st_d.both_low = both_low_now;
		// overdischarge tracker next values
		st_d.od_state = od_state_d;
		st_d.od_cnt = od_cnt_d;
		// enables change only by host write, no mode input gates them
		if (wr_en_lo) begin
			st_d.en_lo = reg_wdata; // R20 R21
		end
		if (wr_en_hi) begin
			st_d.en_hi = reg_wdata; // R20 R22
		end
		// flags: read clears, a gated event in the same cycle still sets
		st_d.flg_lo = efi_flag_next(st_q.flg_lo, rd_flg_lo, ev_lo, st_q.en_lo); // R1 R3 R24
		st_d.flg_hi = efi_flag_next(st_q.flg_hi, rd_flg_hi, ev_hi, st_q.en_hi); // R1 R3 R24
		// read data holds until the next read
		if (reg_rd) begin
			st_d.rdata = rd_mux;
		end
		// irq falls only once every flag is clear
		st_d.irq = efi_any_set(st_d.flg_lo, st_d.flg_hi); // R1 R2 R23 R25
	end

	// state register
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q.en_lo <= EFI_RST_EN_LO; // R21
			st_q.en_hi <= EFI_RST_EN_HI; // R22
			st_q.flg_lo <= EFI_RST_FLG; // R4
			st_q.flg_hi <= EFI_RST_FLG; // R5
			st_q.rdata <= '0;
			st_q.irq <= 1'b0;
			st_q.both_low <= 1'b0;
			st_q.od_state <= EFI_OD_ABOVE;
			st_q.od_cnt <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	// both outputs come straight from the state register
	assign reg_rdata = st_q.rdata;
	assign irq = st_q.irq;

endmodule // efi_event_flags

//--- sim/efi_host_model.sv
`timescale 1ns/1ps
// ****
// host side of the register strobe port
// ****
module efi_host_model (
	input wire logic ref_clk,
	output logic [7:0] reg_addr,
	output logic reg_wr,
	output logic [7:0] reg_wdata,
	output logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic irq
);
	// idle port at time zero
	initial begin
		reg_addr = 8'h00;
		reg_wr = 1'b0;
		reg_wdata = 8'h00;
		reg_rd = 1'b0;
	end
	// one-cycle write strobe
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	// one-cycle read strobe, data taken once the edge has landed
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	// interrupt service: both flag registers, low first
	task automatic serve(output logic [7:0] lo, output logic [7:0] hi);
		rd(8'h18, lo);
		rd(8'h19, hi);
	endtask
endmodule // efi_host_model

//--- sim/efi_event_flags_props.sv
`timescale 1ns/1ps
module efi_event_flags_chk
	import efi_pkg::*;
#(
	parameter int unsigned OVDIS_PERSIST_CYC = efi_pkg::EFI_OVDIS_PERSIST_CYC
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic power_monitor_error,
	input wire logic power_monitor_done,
	input wire logic temp_measure_done,
	input wire logic storage_measure_done,
	input wire logic second_source_track_done,
	input wire logic second_source_track_start,
	input wire logic first_source_track_done,
	input wire logic first_source_track_start,
	input wire logic [efi_pkg::EFI_ADDR_W-1:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [efi_pkg::EFI_DATA_W-1:0] reg_wdata,
	input wire logic reg_rd,
	input wire logic [efi_pkg::EFI_DATA_W-1:0] reg_rdata,
	input wire logic irq
);
	// ****
	// shadow of enables and high flags
	// ****
	logic [7:0] ev, en_lo_q, en_hi_q, fh_q;
	logic rd_lo, rd_hi, rd_unm, flg_rd, ev_on;
	// decode of pulses and read strobes
	assign ev = {power_monitor_error, power_monitor_done, temp_measure_done,
		storage_measure_done, second_source_track_done, second_source_track_start,
		first_source_track_done, first_source_track_start};
	assign rd_lo = reg_rd && reg_addr == EFI_OFS_FLG_LO;
	assign rd_hi = reg_rd && reg_addr == EFI_OFS_FLG_HI;
	assign rd_unm = reg_rd && !(reg_addr inside {8'h15, 8'h16, 8'h18, 8'h19});
	assign flg_rd = rd_lo || rd_hi;
	assign ev_on = (ev & en_hi_q) != 8'h00;
	// set wins over read-clear
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			en_lo_q <= EFI_RST_EN_LO;
			en_hi_q <= EFI_RST_EN_HI;
			fh_q <= EFI_RST_FLG;
		end else begin
			if (reg_wr && reg_addr == EFI_OFS_EN_LO) en_lo_q <= reg_wdata;
			if (reg_wr && reg_addr == EFI_OFS_EN_HI) en_hi_q <= reg_wdata;
			fh_q <= (rd_hi ? 8'h00 : fh_q) | (ev & en_hi_q);
		end
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	sequence s_ev_on;
		ev_on;
	endsequence
	sequence s_rd_hi;
		rd_hi;
	endsequence
	// ****
	// checks
	// ****
	AST_EV_IRQ: assert property (s_ev_on |=> irq)
		else $error("enabled event did not raise irq");
	AST_IRQ_HOLD: assert property (irq && !flg_rd |=> irq)
		else $error("irq dropped without a flag read");
	AST_IRQ_FALL: assert property ($fell(irq) |-> $past(flg_rd) && !$past(ev_on))
		else $error("irq fell without cause");
	AST_HI_READ: assert property (s_rd_hi |=> reg_rdata == $past(fh_q))
		else $error("high flags read wrong");
	AST_EN_HI_RD: assert property (reg_rd && reg_addr == EFI_OFS_EN_HI |=>
		reg_rdata == $past(en_hi_q))
		else $error("high enables read wrong");
	AST_EN_LO_RD: assert property (reg_rd && reg_addr == EFI_OFS_EN_LO |=>
		reg_rdata == $past(en_lo_q))
		else $error("low enables read wrong");
	AST_UNMAPPED: assert property (rd_unm |=> reg_rdata == EFI_RD_UNMAPPED)
		else $error("unmapped read not zero");
	AST_RDATA_HOLD: assert property (!reg_rd |=> $stable(reg_rdata))
		else $error("read data moved without a read");
endmodule // efi_event_flags_chk

//--- sim/testbench.sv
`timescale 1ns/1ps
module testbench;
	import efi_pkg::*;
	logic ref_clk, rst_n, rw, rr, irq;
	logic [10:0] lv;
	logic [7:0] p, ra, wd, rdat, lo, hi;
	int failures, check_count;
	// level input to toggle and low flags expected after it
	int idx[14] = '{0, 2, 3, 5, 6, 7, 8, 10, 9, 9, 0, 5, 10, 7};
	logic [7:0] exl[14] = '{8'h80, 8'h40, 8'h20, 8'h00, 8'h10, 8'h08, 8'h04, 8'h01, 8'h02,
		8'h02, 8'h80, 8'h10, 8'h00, 8'h08};
	efi_event_flags #(.OVDIS_PERSIST_CYC(8)) DUT (
		.ref_clk(ref_clk), .rst_n(rst_n), .charger_connected(lv[0]), .temp_cold_dis(lv[1]),
		.temp_hot_dis(lv[2]), .temp_cold_ch(lv[3]), .temp_hot_ch(lv[4]), .src1_low(lv[5]),
		.src2_low(lv[6]), .sto_above_ovch(lv[7]), .sto_above_chrdy(lv[8]),
		.sto_below_ovdis(lv[9]), .serial_if_ready(lv[10]), .power_monitor_error(p[7]),
		.power_monitor_done(p[6]), .temp_measure_done(p[5]), .storage_measure_done(p[4]),
		.second_source_track_done(p[3]), .second_source_track_start(p[2]),
		.first_source_track_done(p[1]), .first_source_track_start(p[0]), .reg_addr(ra),
		.reg_wr(rw), .reg_wdata(wd), .reg_rd(rr), .reg_rdata(rdat), .irq(irq));
	efi_host_model host (.ref_clk(ref_clk), .reg_addr(ra), .reg_wr(rw), .reg_wdata(wd),
		.reg_rd(rr), .reg_rdata(rdat), .irq(irq));
	// 25 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	// compare and count
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] v;
		host.rd(a, v);
		chk(v, exp);
	endtask
	task automatic pulse(input logic [7:0] v);
		@(posedge ref_clk);
		p <= v;
		@(posedge ref_clk);
		p <= 8'h00;
		#1;
	endtask
	// toggle one level, then let synchroniser and delay run out
	task automatic lvt(input int i);
		@(posedge ref_clk);
		lv[i] <= ~lv[i];
		repeat (20) @(posedge ref_clk);
		#1;
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// watchdog, well past the expected run
	initial begin
		#100000;
		failures++;
		give_verdict();
	end
	// main sequence
	initial begin
		rst_n = 1'b0;
		lv = '0;
		p = '0;
		failures = 0;
		check_count = 0;
		repeat (6) @(posedge ref_clk);
		rst_n <= 1'b1;
		rchk(8'h15, 8'h01);
		rchk(8'h16, 8'h00);
		rchk(8'h17, 8'h00);
		host.wr(8'h18, 8'hFF);
		rchk(8'h18, 8'h00);
		host.wr(8'h19, 8'hFF);
		rchk(8'h19, 8'h00);
		$display("test reset_map done");
		pulse(8'hFF);
		lvt(0);
		chk({7'h00, irq}, 8'h00);
		rchk(8'h18, 8'h00);
		rchk(8'h19, 8'h00);
		$display("test disabled done");
		host.wr(8'h16, 8'hFF);
		rchk(8'h16, 8'hFF);
		for (int i = 0; i < 8; i++) begin
			pulse(8'h01 << i);
			repeat (3) @(posedge ref_clk);
			#1 chk({7'h00, irq}, 8'h01);
			host.serve(lo, hi);
			chk(lo, 8'h00);
			chk(hi, 8'h01 << i);
			chk({7'h00, irq}, 8'h00);
		end
		pulse(8'h20);
		rchk(8'h18, 8'h00);
		chk({7'h00, irq}, 8'h01);
		fork
			rchk(8'h19, 8'h20);
			pulse(8'h40);
		join
		rchk(8'h19, 8'h40);
		$display("test high_group done");
		host.wr(8'h15, 8'hFF);
		rchk(8'h15, 8'hFF);
		for (int i = 0; i < 14; i++) begin
			lvt(idx[i]);
			rchk(8'h18, exl[i]);
		end
		chk({7'h00, irq}, 8'h00);
		$display("test low_group done");
		give_verdict();
	end
endmodule // testbench
bind efi_event_flags efi_event_flags_chk #(.OVDIS_PERSIST_CYC(OVDIS_PERSIST_CYC)) u_chk (
	.ref_clk(ref_clk), .rst_n(rst_n), .power_monitor_error(power_monitor_error),
	.power_monitor_done(power_monitor_done), .temp_measure_done(temp_measure_done),
	.storage_measure_done(storage_measure_done),
	.second_source_track_done(second_source_track_done),
	.second_source_track_start(second_source_track_start),
	.first_source_track_done(first_source_track_done),
	.first_source_track_start(first_source_track_start), .reg_addr(reg_addr),
	.reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.irq(irq));
